/* logic/fepc_pkg.sv */
// Package: constants and carrier types for the 100 Mb/s PCS transmit/receive slice
package fepc_pkg;
  // Code-groups
  localparam logic [4:0] CG_HALT  = 5'h04;  // 00100
  localparam logic [4:0] CG_IDLE  = 5'h1f;  // 11111
  localparam logic [4:0] CG_SSD_J = 5'h18;  // 11000
  localparam logic [4:0] CG_SSD_K = 5'h11;  // 10001
  localparam logic [4:0] CG_ESD_T = 5'h0d;  // 01101
  localparam logic [4:0] CG_ESD_R = 5'h07;  // 00111
  localparam logic [3:0] NIB_PREAMBLE = 4'h5;
  localparam logic [3:0] NIB_INVALID  = 4'h6;

  // Register byte addresses (PHY control register at index 19h)
  localparam logic [7:0] PHY_CONTROL_REGISTER_IDX     = 8'h19;
  localparam logic [9:0] ADDR_PHY_CTRL   = 10'h064;
  localparam logic [9:0] ADDR_RX_CTRL    = 10'h070;
  localparam logic [9:0] ADDR_STATUS     = 10'h074;
  localparam int         EQ_SEL_LSB      = 12;
  localparam int         BYP_DESCR_BIT   = 0;
  localparam int         BYP_DECODE_BIT  = 1;
  localparam int         SYMBOL_MODE_BIT = 2;

  // Equalizer selection
  typedef enum logic [1:0] {
    EQ_ADAPTIVE = 2'h0,
    EQ_OFF      = 2'h1,
    EQ_FIXED    = 2'h2,
    EQ_RSVD     = 2'h3
  } fepc_eq_t;
  localparam logic [1:0] EQ_SEL_RESET = 2'h0;

  // Signal detect qualification: pulses shorter than this are link pulses
  localparam int SD_QUAL_NS     = 200;
  localparam int CLK_PERIOD_NS  = 4;
  localparam int SD_QUAL_CYCLES = (SD_QUAL_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;

  // Receive nibble towards the MAC
  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] data;
  } fepc_rx_nib_t;

  // Transmit nibble from the MAC
  typedef struct packed {
    logic       en;
    logic       er;
    logic [3:0] data;
  } fepc_tx_nib_t;
endpackage : fepc_pkg

/* logic/fepc_top.sv */
// Module: 100 Mb/s PCS transmit error substitution and receive control
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps

// Operation
// - With transmit enable and error both high, each data code-group is sent as halt.
// - Start and end delimiter pairs are still sent around halt code-groups.
// - Signal detect ignores short normal and fast link pulses.
// - In symbol mode the internal signal detect drives carrier sense.
// - Equalizer type comes from bits 13:12 of the PHY control register at 19h.
// - Settings are adaptive, off and fixed maximum; off and fixed are test modes.
// - The serial line stream is delivered as 4-bit nibbles on receive data.
// - Descrambler and 4B/5B decoder each have their own bypass.
// - Three-level line symbols become a binary NRZI stream first.
// - The halt code-group is 00100.
// - Each frame starts with the pair 11000 then 10001 in place of preamble.
// - After enable drops, 01101 then 00111 is sent, then idles.
module fepc_top (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // MII transmit side (same clock)
  input  wire fepc_pkg::fepc_tx_nib_t tx_in,
  output logic      [4:0]            tx_code,
  // Line receive (three-level symbol, one per clock), signal energy pin
  input  wire logic                  line_pos,
  input  wire logic                  line_neg,
  input  wire logic                  line_energy,
  // MII receive side
  output fepc_pkg::fepc_rx_nib_t     rx_out,
  output logic                       carrier_sense,
  output fepc_pkg::fepc_eq_t         equalizer_select
);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  // Data code table, nibble 0 in the low five bits
  localparam logic [79:0] ENC5_TAB = {
    5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16, 5'h13, 5'h12,
    5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e};

  function automatic logic [4:0] enc5(input logic [3:0] n);
    return ENC5_TAB[5 * n +: 5];
  endfunction : enc5

  // Returns {invalid, nibble}
  function automatic logic [4:0] dec5(input logic [4:0] c);
    logic [4:0] r;
    r = {1'b1, fepc_pkg::NIB_INVALID};
    for (int i = 0; i < 16; i++)
      if (enc5(4'(i)) == c)
        r = {1'b0, 4'(i)};
    return r;
  endfunction : dec5

  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  logic        ph_wr_reg;
  logic [9:0]  ph_addr_reg;
  logic [1:0]  eq_sel_reg;
  logic [2:0]  rx_ctrl_reg;
  logic        sd_reg;
  logic        rx_err_seen_reg;
  logic        ap;

  assign ap        = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      ph_wr_reg   <= 1'b0;
      ph_addr_reg <= 10'h000;
    end
    else
    begin
      ph_wr_reg   <= ap && hwrite;
      ph_addr_reg <= haddr[9:0];
    end

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      eq_sel_reg  <= fepc_pkg::EQ_SEL_RESET;
      rx_ctrl_reg <= 3'h0;
    end
    else if (ph_wr_reg)
    begin
      if (ph_addr_reg == fepc_pkg::ADDR_PHY_CTRL)
        eq_sel_reg <= hwdata[fepc_pkg::EQ_SEL_LSB +: 2];
      if (ph_addr_reg == fepc_pkg::ADDR_RX_CTRL)
        rx_ctrl_reg <= hwdata[2:0];
    end

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      hrdata <= 32'h0;
    else if (ap && !hwrite)
    begin
      unique case (haddr[9:0])
        fepc_pkg::ADDR_PHY_CTRL:
          hrdata <= 32'(eq_sel_reg) << fepc_pkg::EQ_SEL_LSB;
        fepc_pkg::ADDR_RX_CTRL:
          hrdata <= {29'h0, rx_ctrl_reg};
        fepc_pkg::ADDR_STATUS:
          hrdata <= {30'h0, rx_err_seen_reg, sd_reg};
        default:
          hrdata <= 32'h0;
      endcase
    end

  // Reserved code 3 behaves as adaptive; off/fixed are test modes only
  always_comb
    unique case (eq_sel_reg)
      2'h1:    equalizer_select = fepc_pkg::EQ_OFF;
      2'h2:    equalizer_select = fepc_pkg::EQ_FIXED;
      default: equalizer_select = fepc_pkg::EQ_ADAPTIVE;
    endcase

  // ------------------------------------------------------------
  // Transmit encoder
  // ------------------------------------------------------------
  typedef enum {TX_IDLE, TX_K, TX_DATA, TX_R} fepc_tx_st_t;
  fepc_tx_st_t tx_st_reg;

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      tx_st_reg <= TX_IDLE;
      tx_code   <= fepc_pkg::CG_IDLE;
    end
    else
    begin
      unique case (tx_st_reg)
        TX_IDLE:
          if (tx_in.en)
          begin
            tx_code   <= fepc_pkg::CG_SSD_J;
            tx_st_reg <= TX_K;
          end
          else
            tx_code <= fepc_pkg::CG_IDLE;
        TX_K:
        begin
          tx_code   <= fepc_pkg::CG_SSD_K;
          tx_st_reg <= TX_DATA;
        end
        TX_DATA:
          if (!tx_in.en)
          begin
            tx_code   <= fepc_pkg::CG_ESD_T;
            tx_st_reg <= TX_R;
          end
          else if (tx_in.er)
            tx_code <= fepc_pkg::CG_HALT;
          else
            tx_code <= enc5(tx_in.data);
        TX_R:
        begin
          tx_code   <= fepc_pkg::CG_ESD_R;
          tx_st_reg <= TX_IDLE;
        end
      endcase
    end

  // ------------------------------------------------------------
  // Receive front: synchronisers, MLT-3 to NRZI, signal detect
  // ------------------------------------------------------------
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic       nrzi_reg;
  logic       nrz_reg;
  logic [7:0] sd_cnt_reg;

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
    end
    else
    begin
      s1_reg <= {line_energy, line_neg, line_pos};
      s2_reg <= s1_reg;
    end

  // Nonzero level is a one; transitions of nrzi then give NRZ ones
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      nrzi_reg <= 1'b0;
      nrz_reg  <= 1'b0;
    end
    else
    begin
      nrzi_reg <= s2_reg[0] | s2_reg[1];
      nrz_reg  <= nrzi_reg ^ (s2_reg[0] | s2_reg[1]);
    end

  // Link pulses are ~100 ns; qualification needs energy for longer
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      sd_cnt_reg <= 8'h00;
      sd_reg     <= 1'b0;
    end
    else if (!s2_reg[2])
    begin
      sd_cnt_reg <= 8'h00;
      sd_reg     <= 1'b0;
    end
    else if (sd_cnt_reg < 8'(fepc_pkg::SD_QUAL_CYCLES))
      sd_cnt_reg <= sd_cnt_reg + 8'h01;
    else
      sd_reg <= 1'b1;

  // ------------------------------------------------------------
  // Receive back end: descramble, align, decode
  // ------------------------------------------------------------
  logic [10:0] lfsr_reg;
  logic [4:0]  sh_reg;
  logic [2:0]  bit_cnt_reg;
  logic        aligned_reg;
  logic        dbit;
  logic [4:0]  dec;

  // Descrambler stream, bypassed by control bit
  assign dbit = rx_ctrl_reg[fepc_pkg::BYP_DESCR_BIT] ?
                nrz_reg : nrz_reg ^ lfsr_reg[10];
  assign dec  = dec5(sh_reg);

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      lfsr_reg <= 11'h7ff;
    else
      lfsr_reg <= {lfsr_reg[9:0], lfsr_reg[10] ^ lfsr_reg[8]};

  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      sh_reg      <= 5'h00;
      bit_cnt_reg <= 3'h0;
      aligned_reg <= 1'b0;
    end
    else
    begin
      sh_reg <= {sh_reg[3:0], dbit};
      if (!sd_reg)
        aligned_reg <= 1'b0;
      else if (!aligned_reg && {sh_reg, dbit} == 6'h31)
      begin
        aligned_reg <= 1'b1;
        bit_cnt_reg <= 3'h0;
      end
      else
        bit_cnt_reg <= (bit_cnt_reg == 3'h4) ? 3'h0 : bit_cnt_reg + 3'h1;
    end

  // One nibble per aligned five-bit code-group
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      rx_out          <= '0;
      rx_err_seen_reg <= 1'b0;
    end
    else if (aligned_reg && bit_cnt_reg == 3'h4)
    begin
      rx_out.dv <= (sh_reg != fepc_pkg::CG_IDLE);
      if (rx_ctrl_reg[fepc_pkg::BYP_DECODE_BIT])
      begin
        rx_out.data <= sh_reg[3:0];
        rx_out.er   <= sh_reg[4];
      end
      else
      begin
        rx_out.data <= dec[3:0];
        rx_out.er   <= dec[4] && (sh_reg != fepc_pkg::CG_IDLE);
        if (dec[4] && sh_reg != fepc_pkg::CG_IDLE)
          rx_err_seen_reg <= 1'b1;
      end
    end
    else if (!aligned_reg)
      rx_out <= '0;

  assign carrier_sense = rx_ctrl_reg[fepc_pkg::SYMBOL_MODE_BIT] ?
                         sd_reg : rx_out.dv;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_halt_subst: assert property (@(posedge clk) disable iff (!reset_n)
    tx_st_reg == TX_DATA && tx_in.en && tx_in.er |=>
      tx_code == fepc_pkg::CG_HALT)
    else $error("halt not substituted");
  a_ssd_pair: assert property (@(posedge clk) disable iff (!reset_n)
    tx_st_reg == TX_IDLE && tx_in.en |=>
      tx_code == fepc_pkg::CG_SSD_J ##1 tx_code == fepc_pkg::CG_SSD_K)
    else $error("start pair wrong");
  a_esd_pair: assert property (@(posedge clk) disable iff (!reset_n)
    tx_st_reg == TX_DATA && !tx_in.en |=>
      tx_code == fepc_pkg::CG_ESD_T ##1 tx_code == fepc_pkg::CG_ESD_R)
    else $error("end pair wrong");
  a_idle_noen: assert property (@(posedge clk) disable iff (!reset_n)
    tx_st_reg == TX_IDLE && !tx_in.en |=> tx_code == fepc_pkg::CG_IDLE)
    else $error("idle not sent");
  a_delim_keep: assert property (@(posedge clk) disable iff (!reset_n)
    tx_st_reg == TX_K |=> tx_code != fepc_pkg::CG_HALT)
    else $error("delimiter replaced");
  a_sd_qual: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(sd_reg) |-> $past(s2_reg[2], 2) && $past(s2_reg[2], 3))
    else $error("signal detect on short pulse");
  a_symbol_crs: assert property (@(posedge clk) disable iff (!reset_n)
    rx_ctrl_reg[fepc_pkg::SYMBOL_MODE_BIT] |-> carrier_sense == sd_reg)
    else $error("carrier sense not signal detect");
  a_eq_write: assert property (@(posedge clk) disable iff (!reset_n)
    ph_wr_reg && ph_addr_reg == fepc_pkg::ADDR_PHY_CTRL |=>
      eq_sel_reg == $past(hwdata[13:12]))
    else $error("equalizer select not written");
  a_nrzi_conv: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 nrzi_reg == $past(s2_reg[0] | s2_reg[1]))
    else $error("nrzi conversion wrong");

  c_err_frame: cover property (@(posedge clk) disable iff (!reset_n)
    tx_code == fepc_pkg::CG_HALT ##[1:50] tx_code == fepc_pkg::CG_ESD_R);
  c_sd_up: cover property (@(posedge clk) disable iff (!reset_n)
    $rose(sd_reg));
  c_rx_align: cover property (@(posedge clk) disable iff (!reset_n)
    $rose(aligned_reg));

endmodule : fepc_top

/* verif/fepc_mac.sv */
// Partner model: MII transmitting MAC, one frame per request
`timescale 1ns/1ps
module fepc_mac (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // Frame request
  input  wire logic                   go,
  input  wire logic                   err,
  input  wire logic [7:0]             len,
  // MII transmit
  output fepc_pkg::fepc_tx_nib_t      tx_in
);
  logic [7:0] left_reg;

  // Error follows err between frames too; the PCS must ignore it there
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      left_reg <= 8'h00;
      tx_in    <= '0;
    end
    else
    begin
      if (go && left_reg == 8'h00)
        left_reg <= len;
      else if (left_reg != 8'h00)
        left_reg <= left_reg - 8'h01;
      tx_in.en   <= (go && left_reg == 8'h00) || left_reg > 8'h01;
      tx_in.er   <= err;
      tx_in.data <= 4'h5;
    end
endmodule : fepc_mac

/* verif/tb_fast_ethernet_pcs_tx_error_rx_control.sv */
// Testbench: register, transmit error and signal detect checks
`timescale 1ns/1ps
module tb_fast_ethernet_pcs_tx_error_rx_control;
  // ----------
  // Signals
  // ----------
  localparam logic [31:0] PHY = 32'(fepc_pkg::ADDR_PHY_CTRL);
  localparam logic [31:0] RXC = 32'(fepc_pkg::ADDR_RX_CTRL);
  typedef struct packed {
    logic [31:0] a, w, m, r;
    logic [1:0]  e;
  } fepc_row_t;
  // Off and fixed are test modes, used here only to see them selected
  fepc_row_t rows [6] = '{
    '{PHY, 32'h1000, 32'h3000, 32'h1000, 2'h1},
    '{PHY, 32'h2000, 32'h3000, 32'h2000, 2'h2},
    '{PHY, 32'h3000, 32'h0000, 32'h0000, 2'h0},
    '{PHY, 32'h0000, 32'h3000, 32'h0000, 2'h0},
    '{RXC, 32'h0003, 32'h0007, 32'h0003, 2'h0},
    '{32'h80, 32'hffffffff, 32'hffffffff, 32'h0, 2'h0}
  };
  logic                   clk, reset_n, hsel, hwrite, hreadyout, hresp;
  logic                   line_pos, line_neg, line_energy;
  logic                   rx_bit, nz = 1'b0, sgn = 1'b0;
  logic [59:0]            pat;
  logic                   carrier_sense, go, err, hi;
  logic [31:0]            haddr, hwdata, hrdata, rd;
  logic [1:0]             htrans;
  logic [2:0]             hsize;
  logic [4:0]             tx_code;
  logic [7:0]             len;
  fepc_pkg::fepc_tx_nib_t tx_in;
  fepc_pkg::fepc_rx_nib_t rx_out;
  fepc_pkg::fepc_eq_t     eq;
  int                     miscompares, n_tests;

  fepc_top uut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .tx_in(tx_in), .tx_code(tx_code), .line_pos(line_pos),
    .line_neg(line_neg), .line_energy(line_energy), .rx_out(rx_out),
    .carrier_sense(carrier_sense), .equalizer_select(eq));
  fepc_mac mac (.clk(clk), .reset_n(reset_n), .go(go), .err(err),
    .len(len), .tx_in(tx_in));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Three-level line: a one bit toggles between zero and the next polarity
  always @(posedge clk)
  begin
    nz <= line_energy & (nz ^ rx_bit);
    if (line_energy && !nz && rx_bit)
      sgn <= ~sgn;
  end
  assign line_pos = nz & sgn;
  assign line_neg = nz & ~sgn;

  // ----------
  // Tasks
  // ----------
  task automatic chk(input string n, input logic [31:0] s, x);
    n_tests++;
    if (s !== x)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [31:0] a, w);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic tx_frame(input logic e, input logic [7:0] n);
    logic [4:0] c [64];
    logic [4:0] x;
    int         j;
    err <= e;
    @(posedge clk);
    len <= n;
    go  <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (int i = 0; i < 64; i++)
    begin
      @(posedge clk);
      c[i] = tx_code;
    end
    j = 0;
    while (j < 40 && c[j] === fepc_pkg::CG_IDLE)
      j++;
    chk("tx_start", 32'(c[j]), 32'(fepc_pkg::CG_SSD_J));
    for (int k = 1; k < n + 3; k++)
    begin
      x = k == 1 ? fepc_pkg::CG_SSD_K : k < n ? (e ? fepc_pkg::CG_HALT
        : 5'h0b) : k == n ? fepc_pkg::CG_ESD_T : k == n + 1 ?
        fepc_pkg::CG_ESD_R : fepc_pkg::CG_IDLE;
      chk("tx_code", 32'(c[j + k]), 32'(x));
    end
    $display("frame of %0d nibbles done", n);
  endtask : tx_frame

  task automatic test_done;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  // ----------
  // Tests
  // ----------
  initial
  begin
    #200000;
    miscompares++;
    test_done;
  end

  initial
  begin
    {reset_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {line_energy, go, err, len} = '0;
    rx_bit = 1'b1;
    hsize = 3'h2;
    miscompares = 0;
    n_tests = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    chk("eq_reset", 32'(eq), 32'h0);
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].a, rows[i].w);
      bus(1'b0, rows[i].a, 32'h0);
      chk("readback", rd & rows[i].m, rows[i].r);
      chk("eq_sel", 32'(eq), 32'(rows[i].e));
      chk("hresp", 32'(hresp), 32'h0);
    end
    $display("register rows done");
    tx_frame(1'b1, 8'd8);
    tx_frame(1'b0, 8'd6);
    tx_frame(1'b1, 8'd3);
    tx_frame(1'b1, 8'd2);
    // A link-pulse length burst must not qualify, a long one must
    bus(1'b1, RXC, 32'h4);
    hi = 1'b0;
    line_energy <= 1'b1;
    for (int i = 0; i < 30; i++)
    begin
      @(posedge clk);
      hi = hi | carrier_sense;
      if (i == 24)
        line_energy <= 1'b0;
    end
    chk("sd_short", 32'(hi), 32'h0);
    line_energy <= 1'b1;
    repeat (70) @(posedge clk);
    chk("sd_long", 32'(carrier_sense), 32'h1);
    // Descrambler bypassed: J K, four data 5 codes, T R, then idles
    bus(1'b1, RXC, 32'h5);
    pat = {fepc_pkg::CG_SSD_J, fepc_pkg::CG_SSD_K, {4{5'h0b}},
           fepc_pkg::CG_ESD_T, fepc_pkg::CG_ESD_R, 20'hfffff};
    hi = 1'b0;
    for (int i = 0; i < 60; i++)
    begin
      rx_bit <= pat[59 - i];
      @(posedge clk);
      hi = hi | (rx_out.dv && !rx_out.er && rx_out.data == 4'h5);
    end
    rx_bit <= 1'b1;
    chk("rx_nibble", 32'(hi), 32'h1);
    $display("receive nibbles done");
    line_energy <= 1'b0;
    $display("signal detect done");
    bus(1'b1, PHY, 32'h2000);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("eq_rerst", 32'(eq), 32'h0);
    reset_n <= 1'b1;
    bus(1'b0, PHY, 32'h0);
    chk("phy_rerst", rd, 32'h0);
    $display("second reset done");
    test_done;
  end
endmodule : tb_fast_ethernet_pcs_tx_error_rx_control
